// *** erai_pkg.sv ***
// constants shared by the e1 receive alarm and event interrupt block
package erai_pkg;
    // register indices; the byte address is four times the index
    localparam logic [11:0] IDX_ALARM_STATUS = 12'hb02;
    localparam logic [11:0] IDX_ALARM_ENABLE = 12'hb03;
    localparam logic [11:0] IDX_FRAMER_STATUS = 12'hb04;
    localparam logic [11:0] IDX_FRAMER_ENABLE = 12'hb05;
    localparam logic [11:0] IDX_FRAMING_CTRL = 12'h010b;
    localparam logic [11:0] IDX_SIG_CHG_FIRST = 12'h010d;
    localparam logic [11:0] IDX_SIG_CHG_LAST = 12'h0110;
    // field positions
    localparam int BIT_YEL_CHG = 0;
    localparam int BIT_AIS_CHG = 1;
    localparam int BIT_YEL_STATE = 7;
    localparam int BIT_SIG_CHG = 5;
    localparam int BIT_NBIT_CHG = 6;
    localparam int BIT_COMFA_CHG = 7;
    localparam int BIT_CAS_ENABLE = 0;
    localparam int CAS_MF_LOSS_THRESHOLD_LSB = 5;
    // writable or settable bits of each register
    localparam logic [7:0] ALARM_MASK = 8'h03;
    localparam logic [7:0] FRAMER_MASK = 8'he0;
    localparam logic [7:0] FRAMING_CTRL_MASK = 8'h61;
    // values after reset
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] FRAMING_CTRL_RESET = 8'h00;
    // channel counts and alarm timing in frames
    localparam int VOICE_CHANNELS = 30;
    localparam int YEL_CONSEC_FRAMES = 2;
    typedef enum logic [1:0] {ERAI_MF_ALIGNED = 2'b00, ERAI_MF_LOST = 2'b01} erai_mf_state_t;
endpackage : erai_pkg

// *** erai_yellow_det.sv ***
// remote alarm detector over consecutive non-fas frames
`timescale 1ns/1ps
module erai_yellow_det
    import erai_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic nfas_strobe,
    input wire logic remote_bit,
    output logic yellow
);
    logic prev_bit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_bit <= 1'b0;
        end else if (nfas_strobe) begin
            prev_bit <= remote_bit;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            yellow <= 1'b0;
        end else if (nfas_strobe && remote_bit == prev_bit) begin
            yellow <= remote_bit;
        end
    end

    yellow_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (nfas_strobe && remote_bit && prev_bit) |=> yellow)
        else $error("yellow not declared after two alarm frames");
    yellow_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (nfas_strobe && !remote_bit && !prev_bit) |=> !yellow)
        else $error("yellow not cleared after two clear frames");
endmodule : erai_yellow_det

// *** erai_casmf_det.sv ***
// cas multiframe alignment loss detector
`timescale 1ns/1ps
module erai_casmf_det
    import erai_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mfas_strobe,
    input wire logic mfas_error,
    input wire logic [1:0] threshold,
    output logic loss
);
    erai_mf_state_t state;
    logic [1:0] err_cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_cnt <= 2'h0;
        end else if (mfas_strobe) begin
            if (!mfas_error || err_cnt == threshold) begin
                err_cnt <= 2'h0;
            end else begin
                err_cnt <= err_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ERAI_MF_ALIGNED;
        end else if (mfas_strobe) begin
            case (state)
                ERAI_MF_ALIGNED: begin
                    if (mfas_error && err_cnt == threshold) begin
                        state <= ERAI_MF_LOST;
                    end
                end
                ERAI_MF_LOST: begin
                    if (!mfas_error) begin
                        state <= ERAI_MF_ALIGNED;
                    end
                end
                default: begin
                    state <= ERAI_MF_ALIGNED;
                end
            endcase
        end
    end

    assign loss = (state == ERAI_MF_LOST);

    casmf_declare_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mfas_strobe && mfas_error && err_cnt == threshold) |=> loss)
        else $error("mf loss not declared at threshold");
endmodule : erai_casmf_det

// *** erai_top.sv ***
// Contract
// - ais change raises interrupt when enabled
// - yellow change raises interrupt when enabled
// - enables gate interrupts, reset to zero
// - status bits sticky, cleared by read
// - mf alignment loss change sets bit seven
// - mf loss after programmed errored count
// - cas flags only active with cas
// - national bit change sets bit six
// - signaling change sets bit five
// - per channel signaling change registers
// - yellow after two equal non-fas frames
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module erai_top
    import erai_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ais_state,
    input wire logic nfas_strobe,
    input wire logic remote_bit,
    input wire logic [4:0] national_bits,
    input wire logic mfas_strobe,
    input wire logic mfas_error,
    input wire logic sig_strobe,
    input wire logic [4:0] sig_channel,
    input wire logic [3:0] sig_abcd,
    output logic irq,
    output logic yellow_alarm
);
    ////////////////////////////////////////////////////////////////////////////
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic yellow;
    logic yellow_d;
    logic ais_d;
    logic cas_loss;
    logic cas_loss_d;
    logic [7:0] alarm_en;
    logic [7:0] framer_en;
    logic [7:0] framing_ctrl;
    logic [7:0] alarm_status;
    logic [7:0] framer_status;
    logic [31:0] sig_chg;
    logic [3:0] sig_mem [VOICE_CHANNELS];
    logic [4:0] nb_prev;
    logic nb_valid;
    logic cas_enable;

    assign cas_enable = framing_ctrl[BIT_CAS_ENABLE];

    erai_yellow_det u_yellow (
        .clk(sys_clk),
        .rst_n(rst_n),
        .nfas_strobe(nfas_strobe),
        .remote_bit(remote_bit),
        .yellow(yellow)
    );

    erai_casmf_det u_casmf (
        .clk(sys_clk),
        .rst_n(rst_n),
        .mfas_strobe(mfas_strobe),
        .mfas_error(mfas_error),
        .threshold(framing_ctrl[CAS_MF_LOSS_THRESHOLD_LSB +: 2]),
        .loss(cas_loss)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: address phase captured, data phase one cycle, no wait states
    logic take;
    logic [11:0] idx;
    logic wr_pend;
    logic [11:0] wr_idx;
    logic rd_alarm;
    logic rd_framer;

    assign take = hsel && hready && htrans[1];
    assign idx = haddr[13:2];
    assign rd_alarm = take && !hwrite && idx == IDX_ALARM_STATUS;
    assign rd_framer = take && !hwrite && idx == IDX_FRAMER_STATUS;

    function automatic logic is_wr(input logic [11:0] target);
        is_wr = wr_pend && wr_idx == target;
    endfunction : is_wr

    function automatic logic [31:0] read_word(input logic [11:0] a);
        read_word = 32'h0000_0000;
        case (a)
            IDX_ALARM_STATUS: read_word[7:0] = alarm_status;
            IDX_ALARM_ENABLE: read_word[7:0] = alarm_en | {yellow, 7'h00};
            IDX_FRAMER_STATUS: read_word[7:0] = framer_status;
            IDX_FRAMER_ENABLE: read_word[7:0] = framer_en;
            IDX_FRAMING_CTRL: read_word[7:0] = framing_ctrl;
            default: begin
                if (a >= IDX_SIG_CHG_FIRST && a <= IDX_SIG_CHG_LAST) begin
                    read_word[7:0] = sig_chg[{a[1:0] - 2'h1, 3'h0} +: 8];
                end
            end
        endcase
    endfunction : read_word

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_idx <= 12'h000;
        end else begin
            wr_pend <= take && hwrite;
            wr_idx <= idx;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take && !hwrite) begin
                hrdata <= read_word(idx);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // enables reset to zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_en <= ENABLE_RESET;
            framer_en <= ENABLE_RESET;
            framing_ctrl <= FRAMING_CTRL_RESET;
        end else begin
            if (is_wr(IDX_ALARM_ENABLE)) begin
                alarm_en <= hwdata[7:0] & ALARM_MASK;
            end
            if (is_wr(IDX_FRAMER_ENABLE)) begin
                framer_en <= hwdata[7:0] & FRAMER_MASK;
            end
            if (is_wr(IDX_FRAMING_CTRL)) begin
                framing_ctrl <= hwdata[7:0] & FRAMING_CTRL_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event detection
    logic sig_event;
    logic [VOICE_CHANNELS-1:0] sig_hit;
    logic [VOICE_CHANNELS-1:0] sig_clr;
    logic nb_event;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            yellow_d <= 1'b0;
            ais_d <= 1'b0;
            cas_loss_d <= 1'b0;
            yellow_alarm <= 1'b0;
        end else begin
            yellow_d <= yellow;
            ais_d <= ais_state;
            cas_loss_d <= cas_loss;
            yellow_alarm <= yellow;
        end
    end

    assign nb_event = nfas_strobe && nb_valid && national_bits != nb_prev;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            nb_prev <= 5'h00;
            nb_valid <= 1'b0;
        end else if (nfas_strobe) begin
            nb_prev <= national_bits;
            nb_valid <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < VOICE_CHANNELS; i++) begin
                sig_mem[i] <= 4'h0;
            end
        end else if (sig_strobe && sig_channel < 5'(VOICE_CHANNELS)) begin
            sig_mem[sig_channel] <= sig_abcd;
        end
    end

    // per channel change bits, set wins over read clear
    genvar ch;
    generate
        for (ch = 0; ch < VOICE_CHANNELS; ch++) begin : g_sig
            assign sig_hit[ch] = cas_enable && sig_strobe && sig_channel == 5'(ch) && sig_abcd != sig_mem[ch];
            assign sig_clr[ch] = take && !hwrite && idx == IDX_SIG_CHG_FIRST + 12'(ch / 8);
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sig_chg <= 32'h0000_0000;
        end else begin
            sig_chg <= {{(32-VOICE_CHANNELS){1'b0}}, (sig_chg[VOICE_CHANNELS-1:0] & ~sig_clr) | sig_hit};
        end
    end

    assign sig_event = |sig_hit;

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] alarm_set;
    logic [7:0] framer_set;
    logic [7:0] alarm_clr;
    logic [7:0] framer_clr;

    always_comb begin
        alarm_set = 8'h00;
        framer_set = 8'h00;
        alarm_set[BIT_AIS_CHG] = ais_state != ais_d;
        alarm_set[BIT_YEL_CHG] = yellow != yellow_d;
        framer_set[BIT_COMFA_CHG] = cas_enable && cas_loss != cas_loss_d;
        framer_set[BIT_NBIT_CHG] = nb_event;
        framer_set[BIT_SIG_CHG] = sig_event;
        alarm_clr = (rd_alarm ? 8'hff : 8'h00) | (is_wr(IDX_ALARM_STATUS) ? hwdata[7:0] : 8'h00);
        framer_clr = (rd_framer ? 8'hff : 8'h00) | (is_wr(IDX_FRAMER_STATUS) ? hwdata[7:0] : 8'h00);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_status <= STATUS_RESET;
            framer_status <= STATUS_RESET;
        end else begin
            alarm_status <= ((alarm_status & ~alarm_clr) | alarm_set) & ALARM_MASK;
            framer_status <= ((framer_status & ~framer_clr) | framer_set) & FRAMER_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(alarm_status & alarm_en) || |(framer_status & framer_en);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    ais_change_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(ais_state) |=> alarm_status[BIT_AIS_CHG])
        else $error("ais change not flagged");
    yel_change_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (yellow != yellow_d) |=> alarm_status[BIT_YEL_CHG])
        else $error("yellow change not flagged");
    irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irq |-> $past(|(alarm_status & alarm_en) || |(framer_status & framer_en)))
        else $error("irq without enabled pending bit");
    read_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (rd_alarm && ais_state == ais_d && yellow == yellow_d) |=> alarm_status == 8'h00)
        else $error("alarm status not cleared by read");
    comfa_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cas_enable && cas_loss != cas_loss_d) |=> framer_status[BIT_COMFA_CHG])
        else $error("mf alignment change not flagged");
    cas_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(framer_status[BIT_SIG_CHG]) |-> $past(cas_enable))
        else $error("signaling flag set without cas");
    nbit_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        nb_event |=> framer_status[BIT_NBIT_CHG])
        else $error("national bit change not flagged");
    sig_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sig_event |=> framer_status[BIT_SIG_CHG] && sig_chg[$past(sig_channel)])
        else $error("signaling change not flagged");
    irq_raise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (|(alarm_status & alarm_en)) |=> irq)
        else $error("irq not raised for enabled pending bit");

    irq_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq));
    read_clear_c: cover property (@(posedge sys_clk) disable iff (!rst_n) rd_framer && framer_status != 8'h00);
    sig_seen_c: cover property (@(posedge sys_clk) disable iff (!rst_n) sig_event);
endmodule : erai_top

// *** erai_top_tb_top.sv ***
// self-checking testbench for the e1 receive alarm and event interrupt block
`timescale 1ns/1ps
module erai_top_tb_top;
    import erai_pkg::*;
    logic sys_clk, arst_n, hsel, hwrite, hreadyout, hresp, irq, yellow_alarm;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic ais_state, nfas_strobe, remote_bit, mfas_strobe, mfas_error, sig_strobe;
    logic [4:0] national_bits, sig_channel;
    logic [3:0] sig_abcd;
    logic [7:0] dummy;
    int n_errors = 0;
    int num_checks = 0;

    erai_top dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ais_state(ais_state), .nfas_strobe(nfas_strobe),
        .remote_bit(remote_bit), .national_bits(national_bits), .mfas_strobe(mfas_strobe),
        .mfas_error(mfas_error), .sig_strobe(sig_strobe), .sig_channel(sig_channel),
        .sig_abcd(sig_abcd), .irq(irq), .yellow_alarm(yellow_alarm)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    // one ahb-lite single word transfer; called just after a rising edge
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        hsel <= 1'b1;
        haddr <= {18'h0_0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask : bus

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [7:0] v;
        bus(1'b1, idx, d, v);
    endtask : wr

    task automatic rd_chk(input string what, input logic [11:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        bus(1'b0, idx, 8'h00, v);
        chk(what, v, exp);
    endtask : rd_chk

    // released frame data is inverted so stale values never look valid
    task automatic frame(input logic a, input logic [4:0] nb);
        nfas_strobe <= 1'b1;
        remote_bit <= a;
        national_bits <= nb;
        @(posedge sys_clk);
        nfas_strobe <= 1'b0;
        remote_bit <= ~a;
        national_bits <= ~nb;
        tick(5);
    endtask : frame

    task automatic mfas(input logic err);
        mfas_strobe <= 1'b1;
        mfas_error <= err;
        @(posedge sys_clk);
        mfas_strobe <= 1'b0;
        mfas_error <= ~err;
        tick(5);
    endtask : mfas

    task automatic sig(input logic [4:0] ch, input logic [3:0] v);
        sig_strobe <= 1'b1;
        sig_channel <= ch;
        sig_abcd <= v;
        @(posedge sys_clk);
        sig_strobe <= 1'b0;
        sig_abcd <= ~v;
        tick(5);
    endtask : sig

    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_errors++;
        results();
    end

    initial begin
        logic [4:0] chs [3];
        logic [7:0] exp_sig [4];
        chs = '{5'h00, 5'h09, 5'h1d};
        exp_sig = '{8'h01, 8'h02, 8'h00, 8'h20};
        arst_n = 1'b0;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {ais_state, nfas_strobe, remote_bit, national_bits} = '0;
        {mfas_strobe, mfas_error, sig_strobe, sig_channel, sig_abcd} = '0;
        tick(20);
        arst_n <= 1'b1;
        tick(3);
        rd_chk("alarm_enable", IDX_ALARM_ENABLE, ENABLE_RESET);
        rd_chk("alarm_status", IDX_ALARM_STATUS, STATUS_RESET);
        rd_chk("framer_status", IDX_FRAMER_STATUS, STATUS_RESET);
        rd_chk("unmapped", 12'h100, 8'h00);
        chk("hresp", {7'h00, hresp}, 8'h00);
        chk("irq", {7'h00, irq}, 8'h00);
        wr(IDX_ALARM_ENABLE, 8'h02);
        rd_chk("alarm_enable", IDX_ALARM_ENABLE, 8'h02);
        // ais declared then cleared
        for (int i = 0; i < 2; i++) begin
            ais_state <= (i == 0);
            tick(5);
            chk("irq", {7'h00, irq}, 8'h01);
            rd_chk("alarm_status", IDX_ALARM_STATUS, 8'h02);
            rd_chk("alarm_status", IDX_ALARM_STATUS, 8'h00);
            tick(2);
            chk("irq", {7'h00, irq}, 8'h00);
        end
        wr(IDX_ALARM_ENABLE, 8'h00);
        ais_state <= 1'b1;
        tick(5);
        chk("irq", {7'h00, irq}, 8'h00);
        wr(IDX_ALARM_STATUS, 8'h02);
        rd_chk("alarm_status", IDX_ALARM_STATUS, 8'h00);
        // yellow declared after two frames, cleared after two
        wr(IDX_ALARM_ENABLE, 8'h01);
        frame(1'b1, 5'h00);
        chk("yellow", {7'h00, yellow_alarm}, 8'h00);
        frame(1'b1, 5'h00);
        chk("yellow", {7'h00, yellow_alarm}, 8'h01);
        chk("irq", {7'h00, irq}, 8'h01);
        rd_chk("alarm_enable", IDX_ALARM_ENABLE, 8'h81);
        rd_chk("alarm_status", IDX_ALARM_STATUS, 8'h01);
        frame(1'b0, 5'h00);
        chk("yellow", {7'h00, yellow_alarm}, 8'h01);
        frame(1'b0, 5'h00);
        chk("yellow", {7'h00, yellow_alarm}, 8'h00);
        rd_chk("alarm_status", IDX_ALARM_STATUS, 8'h01);
        wr(IDX_ALARM_ENABLE, 8'h00);
        // national bits, each position in turn
        rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h00);
        wr(IDX_FRAMER_ENABLE, 8'h40);
        frame(1'b0, 5'h10);
        chk("irq", {7'h00, irq}, 8'h01);
        rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h40);
        frame(1'b0, 5'h10);
        rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h00);
        for (int i = 0; i < 5; i++) begin
            frame(1'b0, 5'h01 << i);
            rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h40);
        end
        wr(IDX_FRAMER_ENABLE, 8'he0);
        // cas disabled: no cas events
        repeat (5) mfas(1'b1);
        sig(5'h03, 4'hf);
        rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h00);
        chk("irq", {7'h00, irq}, 8'h00);
        mfas(1'b0);
        rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h00);
        bus(1'b0, IDX_SIG_CHG_FIRST, 8'h00, dummy);
        // every loss threshold, declare and clear
        for (int t = 0; t < 4; t++) begin
            wr(IDX_FRAMING_CTRL, {1'b0, 2'(t), 4'h0, 1'b1});
            repeat (t) mfas(1'b1);
            rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h00);
            mfas(1'b1);
            chk("irq", {7'h00, irq}, 8'h01);
            rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h80);
            mfas(1'b0);
            rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h80);
        end
        // signaling changes per channel
        sig(5'h00, 4'h0);
        rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h00);
        sig(5'h1e, 4'hf);
        rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h00);
        for (int i = 0; i < 3; i++) begin
            sig(chs[i], 4'ha);
            rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h20);
        end
        for (int k = 0; k < 4; k++) begin
            rd_chk("sig_change", IDX_SIG_CHG_FIRST + 12'(k), exp_sig[k]);
        end
        rd_chk("sig_change", IDX_SIG_CHG_LAST, 8'h00);
        for (int b = 0; b < 4; b++) begin
            sig(5'h1d, 4'ha ^ (4'h1 << b));
            rd_chk("framer_status", IDX_FRAMER_STATUS, 8'h20);
            rd_chk("sig_change", IDX_SIG_CHG_LAST, 8'h20);
        end
        results();
    end
endmodule : erai_top_tb_top
